// file: ddr2_bank_state.sv
/*
 * open/idle state of every bank; closes one bank or all on precharge.
 * assumes commands arrive already decoded on ref_clk.
 */
`timescale 1ns/1ps

module ddr2_bank_state #(
    parameter int BANKS = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             nrst,
    input  wire logic             act_en,
    input  wire logic             pre_en,
    input  wire logic             pre_all,
    input  wire logic [2:0]       bank,
    output logic      [BANKS-1:0] open_q
);

    initial begin
        if (BANKS < 1 || BANKS > 8) $error("banks must be 1..8");
    end

    logic [BANKS-1:0] open_d;

    always_comb begin
        open_d = open_q;
        for (int i = 0; i < BANKS; i++) begin
            if (act_en && bank == 3'(i)) begin
                open_d[i] = 1'b1;
            end
            // all-bank close ignores the bank field
            if (pre_en && (pre_all || bank == 3'(i))) begin
                open_d[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            open_q <= '0;
        end else begin
            open_q <= open_d;
        end
    end

endmodule

// file: ddr2_ctrl_model.sv
/* controller-side strobe and data driver for two byte lanes.
   assumes the bench starts a burst once the device window is open. */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module ddr2_ctrl_model (
    output logic [1:0]  dqs_clk,
    output logic [15:0] dq_in
);
    initial begin
        dqs_clk = 2'b00;
        dq_in   = 16'h0000;
    end
    // pairs run back to back so bursts stream without gaps
    task automatic send(input int pairs, input logic [7:0] s);
        logic [7:0] e;
        #2.1;
        for (int p = 0; p < pairs; p++) begin
            e = s + 8'(4 * p);
            dq_in = {e + 8'h02, e};
            #7.5 dqs_clk = 2'b11;
            #7.5 dq_in = {e + 8'h03, e + 8'h01};
            #7.5 dqs_clk = 2'b00;
            #7.5;
        end
        dq_in = ~dq_in; // released bus shows no stale value
    endtask
endmodule

// file: ddr2_strobe_capture.sv
/*
 * captures one byte lane on both strobe edges in the link domain and
 * hands each pair (rise, fall) to the core domain by a toggle crossing.
 * assumes the strobe is held low outside bursts (preamble/postamble).
 */
`timescale 1ns/1ps

module ddr2_strobe_capture #(
    parameter int LANE_W = 8
) (
    input  wire logic              dqs_clk,
    input  wire logic              ref_clk,
    input  wire logic              nrst,
    input  wire logic [LANE_W-1:0] dq_in,
    output logic      [2*LANE_W-1:0] pair_q,
    output logic                   pair_valid_q
);

    initial begin
        if (LANE_W < 1) $error("lane width must be positive");
    end

    ////////////////////////////////////////////////////////////////////
    // link side: the first rising edge after the preamble takes the
    // first element, each falling edge the next
    logic [LANE_W-1:0]   rise_q;
    logic [2*LANE_W-1:0] hold_q;
    // power-up value: this domain has no reset of its own, and an
    // unknown toggle would never show a change to the core side
    logic                tog_q = 1'b0;

    always_ff @(posedge dqs_clk) begin
        rise_q <= dq_in;
    end

    // no reset here: the strobe stops outside bursts, so the toggle
    // only needs a known start, which the power-up value gives
    always_ff @(negedge dqs_clk) begin
        hold_q <= {dq_in, rise_q};
        tog_q  <= ~tog_q;
    end

    ////////////////////////////////////////////////////////////////////
    // core side: two flops on the toggle, then an edge detect
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic [2*LANE_W-1:0] pair_d;
    logic                valid_d;

    always_comb begin
        valid_d = s2_q ^ s3_q;
        pair_d  = valid_d ? hold_q : pair_q;
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            s1_q         <= 1'b0;
            s2_q         <= 1'b0;
            s3_q         <= 1'b0;
            pair_q       <= '0;
            pair_valid_q <= 1'b0;
        end else begin
            s1_q         <= tog_q;
            s2_q         <= s1_q;
            s3_q         <= s2_q;
            pair_q       <= pair_d;
            pair_valid_q <= valid_d;
        end
    end

endmodule

// file: ddr2_wr_checker.sv
/* concurrent checks on the top ports of the write path.
   assumes it is bound to the top module by the bench. */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module ddr2_wr_checker
    import ddr2_wr_pkg::*;
#(
    parameter int BANKS = 8
) (
    input wire logic             ref_clk,
    input wire logic             nrst,
    input wire logic [2:0]       cmd,
    input wire logic [2:0]       bank,
    input wire logic [13:0]      addr,
    input wire logic             wr_data_valid_q,
    input wire logic [13:0]      wr_col_q,
    input wire logic             dq_oe_q,
    input wire logic [BANKS-1:0] bank_open_q,
    input wire logic             burst_busy_q
);
    logic [7:0] since_wr_q;
    logic [7:0] since_wr_d;
    logic [7:0] since_act_q;
    logic [7:0] since_act_d;
    // saturating ages of the last write and activate, for cause checks
    always_comb begin
        since_wr_d  = since_wr_q + {7'h00, since_wr_q != 8'hff};
        since_act_d = since_act_q + {7'h00, since_act_q != 8'hff};
        if (cmd == CMD_WRITE) since_wr_d = 8'h00;
        if (cmd == CMD_ACT) since_act_d = 8'h00;
        if (!nrst) since_wr_d = 8'hff;
        if (!nrst) since_act_d = 8'hff;
    end
    always_ff @(posedge ref_clk) begin
        since_wr_q  <= since_wr_d;
        since_act_q <= since_act_d;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // bank must stay put while the precharge crosses the input flops
    sequence s_idle2;
        (!burst_busy_q && $stable(bank))[*2];
    endsequence
    sequence s_pre_one;
        cmd == CMD_PRE && !addr[10] && !burst_busy_q ##1 s_idle2;
    endsequence
    sequence s_pre_all;
        cmd == CMD_PRE && addr[10] && !burst_busy_q ##1 s_idle2;
    endsequence
    a_oe_never: assert property (dq_oe_q == 1'b0)
        else $error("data pins driven");
    a_busy_cause: assert property ($rose(burst_busy_q) |-> since_wr_q <= 8'h0c)
        else $error("burst window without write");
    a_valid_pulse: assert property (wr_data_valid_q |=> !wr_data_valid_q[*4])
        else $error("pair pulses too close");
    a_open_cause: assert property (|(bank_open_q & ~$past(bank_open_q))
        |-> since_act_q <= 8'h06)
        else $error("bank opened without activate");
    a_pre_one: assert property (s_pre_one |-> ##[1:4] !bank_open_q[bank])
        else $error("single precharge left bank open");
    a_pre_all: assert property (s_pre_all |-> ##[1:4] bank_open_q == '0)
        else $error("precharge all left banks open");
    a_close_idle: assert property (|($past(bank_open_q) & ~bank_open_q)
        |-> !burst_busy_q)
        else $error("bank closed inside a burst");
    a_col_hold: assert property (!$stable(wr_col_q) |-> since_wr_q <= 8'h06)
        else $error("column changed without write");
endmodule

// file: ddr2_wr_pkg.sv
/*
 * types shared by the write-path model.
 * assumes nothing; the constants stay in ddr2_wr_regs.svh.
 */
package ddr2_wr_pkg;

    typedef enum logic [2:0] {
        CMD_NOP   = 3'b000,
        CMD_ACT   = 3'b001,
        CMD_WRITE = 3'b010,
        CMD_READ  = 3'b011,
        CMD_PRE   = 3'b100
    } cmd_e;

    typedef enum logic [1:0] {
        WS_IDLE  = 2'b00,
        WS_WAIT  = 2'b01,
        WS_BURST = 2'b10
    } wstate_e;

    typedef logic [2:0] bank_t;

endpackage

// file: ddr2_wr_regs.svh
/*
 * constants of the write-burst and precharge model: timing counts,
 * field positions of the mode word and address, and reset values.
 * assumes nothing; definitions only.
 */
`ifndef DDR2_WR_REGS_SVH
`define DDR2_WR_REGS_SVH

`define CK_PERIOD_PS        5000
`define TWR_PS              15000
`define TWR_CK              ((`TWR_PS + `CK_PERIOD_PS - 1) / `CK_PERIOD_PS)
`define WR_FIELD_LSB        9
`define WR_FIELD_MSB        11
`define AP_BIT              10
`define BL_FIELD_LSB        0
`define BL_FIELD_MSB        2
`define BL_CODE_4           3'h3
`define BL_CODE_8           3'h2
`define TRUNC_SPACING       4'h2
`define RESET_WL            4'h2
`define RESET_WR            3'h2

`endif

// file: ddr2_wr_tb.sv
/* self-checking bench of the write and precharge path.
   assumes the controller model drives strobes and data. */
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] %0t mismatch %h vs %h", $time, (g), (e)); end end
////////////////////////////////////////////////////////////////////////
module tb;
    import ddr2_wr_pkg::*;
    logic        ref_clk = 1'b0;
    logic        nrst;
    logic [2:0]  cmd;
    logic [2:0]  bank;
    logic [13:0] addr;
    logic [3:0]  read_latency;
    logic [13:0] mode_word;
    wire  [1:0]  dqs_clk;
    wire  [15:0] dq_in;
    logic [31:0] wr_data_q;
    logic        wr_data_valid_q;
    logic [2:0]  wr_bank_q;
    logic [13:0] wr_col_q;
    logic        dq_oe_q;
    logic [7:0]  bank_open_q;
    logic        burst_busy_q;
    int          n_fail = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    ddr2_write_precharge #(.LANES(2), .LANE_W(8), .BANKS(8)) dut (
        .ref_clk(ref_clk), .nrst(nrst), .dqs_clk(dqs_clk), .dq_in(dq_in),
        .cmd(cmd), .bank(bank), .addr(addr), .read_latency(read_latency),
        .mode_word(mode_word), .wr_data_q(wr_data_q),
        .wr_data_valid_q(wr_data_valid_q), .wr_bank_q(wr_bank_q),
        .wr_col_q(wr_col_q), .dq_oe_q(dq_oe_q), .bank_open_q(bank_open_q),
        .burst_busy_q(burst_busy_q));
    ddr2_ctrl_model ctrl (.dqs_clk(dqs_clk), .dq_in(dq_in));
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            final_report();
        end
    end
    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic issue(input logic [2:0] c, input logic [2:0] b,
                         input logic [13:0] a);
        @(negedge ref_clk);
        cmd = c;
        bank = b;
        addr = a;
        @(negedge ref_clk);
        cmd = CMD_NOP;
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic wait_busy(input logic lvl);
        for (int i = 0; i < 40 && burst_busy_q !== lvl; i++)
            @(negedge ref_clk);
    endtask
    task automatic collect(input int pairs, input logic [7:0] s,
                           output int got);
        logic [7:0] e;
        got = 0;
        repeat (pairs * 6 + 16) begin
            @(negedge ref_clk);
            if (wr_data_valid_q === 1'b1) begin
                e = s + 8'(4 * got);
                `CHK(wr_data_q, {e + 8'h03, e + 8'h02, e + 8'h01, e})
                got++;
            end
        end
    endtask
    task automatic burst(input int pairs, input logic [7:0] s,
                         output int got);
        fork
            ctrl.send(pairs, s);
            collect(pairs, s, got);
        join
    endtask
    task automatic t_banks();
        issue(CMD_ACT, 3'h1, '0);
        idle(6);
        issue(CMD_ACT, 3'h3, '0);
        idle(6);
        issue(CMD_ACT, 3'h5, '0);
        idle(6);
        `CHK(bank_open_q, 8'h2a)
        issue(CMD_PRE, 3'h3, 14'h0000);
        idle(8);
        `CHK(bank_open_q, 8'h22)
        issue(CMD_PRE, 3'h1, 14'h0400);
        idle(8);
        `CHK(bank_open_q, 8'h00)
    endtask
    task automatic t_write();
        int got;
        issue(CMD_ACT, 3'h2, '0);
        idle(6);
        issue(CMD_WRITE, 3'h2, 14'h0048);
        wait_busy(1'b1);
        `CHK(burst_busy_q, 1'b1)
        burst(2, 8'h10, got);
        `CHK(got, 2)
        `CHK(wr_bank_q, 3'h2)
        `CHK(wr_col_q, 14'h0048)
        `CHK(bank_open_q[2], 1'b1)
        wait_busy(1'b0);
        burst(1, 8'h80, got);
        `CHK(got, 0)
        `CHK(dq_oe_q, 1'b0)
    endtask
    task automatic t_autopre();
        int n;
        n = 0;
        issue(CMD_WRITE, 3'h2, 14'h0420);
        wait_busy(1'b1);
        fork
            ctrl.send(2, 8'h30);
            begin
                wait_busy(1'b0);
                for (n = 0; n < 20 && bank_open_q[2] === 1'b1; n++)
                    @(negedge ref_clk);
            end
        join
        // recovery field 2 means three clocks after the busy flag falls
        `CHK(n, 3)
    endtask
    task automatic t_concat();
        int got;
        issue(CMD_WRITE, 3'h2, 14'h0008);
        issue(CMD_WRITE, 3'h2, 14'h000c);
        wait_busy(1'b1);
        burst(4, 8'ha0, got);
        `CHK(got, 4)
        `CHK(wr_col_q, 14'h000c)
    endtask
    task automatic t_trunc();
        int got;
        @(negedge ref_clk);
        mode_word = 14'h0402;
        issue(CMD_ACT, 3'h4, '0);
        idle(6);
        issue(CMD_ACT, 3'h6, '0);
        idle(6);
        issue(CMD_WRITE, 3'h4, 14'h0010);
        issue(CMD_WRITE, 3'h6, 14'h0030);
        issue(CMD_PRE, 3'h4, 14'h0000);
        `CHK(burst_busy_q, 1'b1)
        burst(6, 8'h50, got);
        `CHK(got, 6)
        `CHK(wr_bank_q, 3'h6)
        `CHK(wr_col_q, 14'h0030)
        `CHK(bank_open_q[4], 1'b1)
        idle(10);
        issue(CMD_PRE, 3'h0, 14'h0400);
        idle(8);
        `CHK(bank_open_q, 8'h00)
    endtask
    initial begin
        nrst = 1'b0;
        cmd = CMD_NOP;
        bank = '0;
        addr = '0;
        read_latency = 4'h3;
        mode_word = 14'h0403;
        repeat (2) @(negedge ref_clk);
        nrst = 1'b1;
        `CHK(bank_open_q, 8'h00)
        `CHK(burst_busy_q, 1'b0)
        `CHK(wr_data_valid_q, 1'b0)
        t_banks();
        t_write();
        t_concat();
        t_autopre();
        t_trunc();
        final_report();
    end
endmodule
bind ddr2_write_precharge ddr2_wr_checker #(.BANKS(BANKS)) u_chk (
    .ref_clk(ref_clk), .nrst(nrst), .cmd(cmd), .bank(bank), .addr(addr),
    .wr_data_valid_q(wr_data_valid_q), .wr_col_q(wr_col_q),
    .dq_oe_q(dq_oe_q), .bank_open_q(bank_open_q),
    .burst_busy_q(burst_busy_q));

// file: ddr2_write_precharge.sv
/*
 * device-side write path: accepts WRITE/PRECHARGE/ACTIVATE commands,
 * times the burst window by write latency, takes strobe-captured data
 * per byte lane, closes rows by explicit or auto precharge.
 * assumes the controller keeps strobe preamble, postamble, spacing and
 * recovery times; the strobe arrives as the link clock of each lane.
 */
`timescale 1ns/1ps
`include "ddr2_wr_regs.svh"

// What this block does
// - write latency is read latency minus one clock.
// - WRITE carries bank, column and auto-precharge; auto closes row after burst.
// - first element on first rising strobe edge, then every strobe edge.
// - after a burst, data pins stay released and extra data is ignored.
// - a length-eight write without auto precharge is cut only by WRITE.
// - auto-precharge recovery clocks come from mode field bits 9 to 11.
// - on x16, lower strobe takes lower byte, upper strobe upper byte.
// - explicit precharge closes one bank or all; auto precharge closes only the written bank.
// - A10 on PRECHARGE picks all banks; else bank address picks one.
// - A10 on WRITE enables auto precharge when high.
module ddr2_write_precharge
    import ddr2_wr_pkg::*;
#(
    parameter int LANES  = 2,
    parameter int LANE_W = 8,
    parameter int BANKS  = 8
) (
    input  wire logic                      ref_clk,
    input  wire logic                      nrst,
    input  wire logic [LANES-1:0]          dqs_clk,
    input  wire logic [LANES*LANE_W-1:0]   dq_in,
    input  wire logic [2:0]                cmd,
    input  wire logic [2:0]                bank,
    input  wire logic [13:0]               addr,
    input  wire logic [3:0]                read_latency,
    input  wire logic [13:0]               mode_word,
    output logic      [2*LANES*LANE_W-1:0] wr_data_q,
    output logic                           wr_data_valid_q,
    output logic      [2:0]                wr_bank_q,
    output logic      [13:0]               wr_col_q,
    output logic                           dq_oe_q,
    output logic      [BANKS-1:0]          bank_open_q,
    output logic                           burst_busy_q
);

    initial begin
        if (LANES < 1 || LANES > 2) $error("lanes must be 1 or 2");
        if (BANKS < 1 || BANKS > 8) $error("banks must be 1..8");
    end

    function automatic logic [3:0] half_burst(input logic [2:0] code);
        half_burst = (code == `BL_CODE_8) ? 4'h4 : 4'h2;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // pin inputs pass two flops before the decoder reads them
    logic [2:0]  cmd_s1_q,  cmd_s2_q;
    logic [2:0]  bank_s1_q, bank_s2_q;
    logic [13:0] addr_s1_q, addr_s2_q;
    logic [3:0]  rl_s1_q,   rl_s2_q;
    logic [13:0] mode_s1_q, mode_s2_q;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cmd_s1_q  <= 3'h0;
            cmd_s2_q  <= 3'h0;
            bank_s1_q <= 3'h0;
            bank_s2_q <= 3'h0;
            addr_s1_q <= 14'h0000;
            addr_s2_q <= 14'h0000;
            rl_s1_q   <= 4'h0;
            rl_s2_q   <= 4'h0;
            mode_s1_q <= 14'h0000;
            mode_s2_q <= 14'h0000;
        end else begin
            cmd_s1_q  <= cmd;
            cmd_s2_q  <= cmd_s1_q;
            bank_s1_q <= bank;
            bank_s2_q <= bank_s1_q;
            addr_s1_q <= addr;
            addr_s2_q <= addr_s1_q;
            rl_s1_q   <= read_latency;
            rl_s2_q   <= rl_s1_q;
            mode_s1_q <= mode_word;
            mode_s2_q <= mode_s1_q;
        end
    end

    logic       is_wr, is_pre, is_act;
    logic [2:0] bl_code;
    logic [3:0] half_bl;
    logic [2:0] wr_rec;
    logic [3:0] wl_now;

    always_comb begin
        is_wr   = cmd_s2_q == CMD_WRITE;
        is_pre  = cmd_s2_q == CMD_PRE;
        is_act  = cmd_s2_q == CMD_ACT;
        bl_code = mode_s2_q[`BL_FIELD_MSB:`BL_FIELD_LSB];
        half_bl = half_burst(bl_code);
        wr_rec  = mode_s2_q[`WR_FIELD_MSB:`WR_FIELD_LSB] + 3'h1;
        // latency below one clock is clamped so the window still opens
        wl_now  = (rl_s2_q > 4'h1) ? rl_s2_q - 4'h1 : 4'h1;
    end

    ////////////////////////////////////////////////////////////////////
    // burst window timing
    wstate_e    st_q, st_d;
    logic [3:0] cnt_q, cnt_d;
    logic [3:0] len_q, len_d;
    logic [3:0] since_q, since_d;
    logic       ap_q, ap_d;
    logic [2:0] bk_q, bk_d;
    logic [13:0] col_q, col_d;
    logic [3:0] rec_q, rec_d;
    logic       rec_on_q, rec_on_d;
    logic [2:0] rec_bk_q, rec_bk_d;
    logic       auto_pre;
    logic       trunc_ok;
    logic [2*LANES*LANE_W-1:0] lane_pair;
    logic [LANES-1:0]          lane_valid;

    always_comb begin
        st_d     = st_q;
        cnt_d    = cnt_q;
        len_d    = len_q;
        ap_d     = ap_q;
        bk_d     = bk_q;
        col_d    = col_q;
        rec_d    = rec_q;
        rec_on_d = rec_on_q;
        rec_bk_d = rec_bk_q;
        auto_pre = 1'b0;
        since_d  = (since_q == 4'hf) ? since_q : since_q + 4'h1;
        // only a WRITE two clocks into a non-auto length-eight burst
        // may truncate it
        trunc_ok = (st_q != WS_IDLE) && bl_code == `BL_CODE_8 && !ap_q
                   && since_q == `TRUNC_SPACING - 4'h1;
        // recovery runs down before the burst logic, so a burst that
        // ends in the same cycle still loads a fresh close request
        if (rec_on_q) begin
            if (rec_q == 4'h0) begin
                rec_on_d = 1'b0;
                auto_pre = 1'b1;
            end else begin
                rec_d = rec_q - 4'h1;
            end
        end
        case (st_q)
            WS_IDLE: st_d = WS_IDLE;
            WS_WAIT: begin
                if (cnt_q == 4'h0) begin
                    st_d = WS_BURST;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            // the window counts strobe pairs, not clocks: the strobe
            // runs on its own clock and may be far slower than this one
            WS_BURST: begin
                if (&lane_valid) begin
                    len_d = len_q - 4'h1;
                    if (len_q <= 4'h1) begin
                        st_d = WS_IDLE;
                        if (ap_q) begin
                            rec_on_d = 1'b1;
                            rec_d    = {1'b0, wr_rec};
                            rec_bk_d = bk_q;
                        end
                    end
                end
            end
            default: st_d = WS_IDLE;
        endcase
        // a WRITE into an open window queues its pairs behind it; the
        // later WRITE takes over bank and auto precharge, so a pending
        // auto precharge of the earlier one is not kept
        if (is_wr) begin
            if (trunc_ok) begin
                // the cut burst keeps its first four elements
                len_d = len_d - 4'h2 + half_bl;
            end else if (st_q == WS_IDLE) begin
                st_d  = WS_WAIT;
                cnt_d = wl_now - 4'h1;
                len_d = half_bl;
            end else begin
                len_d = len_d + half_bl;
                if (st_q == WS_BURST) begin
                    st_d = WS_BURST;
                end
            end
            ap_d    = addr_s2_q[`AP_BIT];
            bk_d    = bank_s2_q;
            col_d   = addr_s2_q;
            since_d = 4'h0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            st_q     <= WS_IDLE;
            cnt_q    <= 4'h0;
            len_q    <= 4'h2;
            since_q  <= 4'hf;
            ap_q     <= 1'b0;
            bk_q     <= 3'h0;
            col_q    <= 14'h0000;
            rec_q    <= 4'h0;
            rec_on_q <= 1'b0;
            rec_bk_q <= 3'h0;
        end else begin
            st_q     <= st_d;
            cnt_q    <= cnt_d;
            len_q    <= len_d;
            since_q  <= since_d;
            ap_q     <= ap_d;
            bk_q     <= bk_d;
            col_q    <= col_d;
            rec_q    <= rec_d;
            rec_on_q <= rec_on_d;
            rec_bk_q <= rec_bk_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // per-lane strobe capture; each strobe owns its byte
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        ddr2_strobe_capture #(
            .LANE_W (LANE_W)
        ) u_cap (
            .dqs_clk      (dqs_clk[g]),
            .ref_clk      (ref_clk),
            .nrst         (nrst),
            .dq_in        (dq_in[g*LANE_W +: LANE_W]),
            .pair_q       (lane_pair[g*2*LANE_W +: 2*LANE_W]),
            .pair_valid_q (lane_valid[g])
        );
    end

    // pairs that arrive outside a burst window still load wr_data_q but raise no valid
    logic in_burst;
    logic [2*LANES*LANE_W-1:0] data_d;

    always_comb begin
        in_burst = st_q == WS_BURST;
        data_d   = (&lane_valid) ? lane_pair : wr_data_q;
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            wr_data_q       <= '0;
            wr_data_valid_q <= 1'b0;
            wr_bank_q       <= 3'h0;
            wr_col_q        <= 14'h0000;
            dq_oe_q         <= 1'b0;
            burst_busy_q    <= 1'b0;
        end else begin
            wr_data_q       <= data_d;
            wr_data_valid_q <= (&lane_valid) && in_burst;
            wr_bank_q       <= bk_q;
            wr_col_q        <= col_q;
            dq_oe_q         <= 1'b0; // write path never drives
            burst_busy_q    <= st_q != WS_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // bank state; explicit precharge while a burst runs is refused
    logic       pre_en, pre_all;
    logic [2:0] pre_bank;

    always_comb begin
        pre_en   = auto_pre || (is_pre && st_q == WS_IDLE);
        pre_all  = !auto_pre && addr_s2_q[`AP_BIT];
        pre_bank = auto_pre ? rec_bk_q : bank_s2_q;
    end

    ddr2_bank_state #(
        .BANKS (BANKS)
    ) u_banks (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .act_en  (is_act),
        .pre_en  (pre_en),
        .pre_all (pre_all),
        .bank    (pre_bank),
        .open_q  (bank_open_q)
    );

endmodule
